// >>> design/fss_suspend_gate.sv
// command admission and program/erase suspend control of a serial flash
`timescale 1ns/1ps
`include "fss_regs.svh"

module fss_suspend_gate (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // serial pins, asynchronous to clk_i
  input  wire logic          cs_n_i,
  input  wire logic          sck_i,
  input  wire logic          si_i,
  // device core
  input  wire logic          write_latch_flag_i,
  input  wire logic          op_done_i,
  output fss_pkg::fss_cmd_s  cmd_o,
  output logic               cmd_go_o,
  output logic               cmd_refused_o,
  output logic               halt_req_o,
  output logic               read_undef_o,
  output fss_pkg::fss_stat_s status_o
);
  import fss_pkg::*;

  // --------------------------------------------------------------------
  // opcode decoding
  // --------------------------------------------------------------------
  function automatic fss_cls_e classify(input logic [7:0] op);
    fss_cls_e c;
    c = FSS_CL_OTHER;
    case (op)
      `OP_RDSR_1, `OP_RDSR_2, `OP_RDSR_3, `OP_RDSR_IND,
      `OP_TERMINATE, `OP_RST_EN, `OP_RST: c = FSS_CL_ANY;
      `OP_ID_JEDEC, `OP_ID_MFG, `OP_ID_QUAD: c = FSS_CL_ANY;
      `OP_RDPD: c = FSS_CL_ANY;
      `OP_DPD, `OP_UDPD: c = FSS_CL_OTHER;
      `OP_OTP_READ: c = FSS_CL_SUSPOK;
      `OP_RD_LKS_A, `OP_RD_LKS_B: c = FSS_CL_SUSPOK;
      `OP_WREN, `OP_WRDI, `OP_VWREN, `OP_WRAP,
      `OP_SFDP: c = FSS_CL_SUSPOK;
      `OP_READ, `OP_FREAD, `OP_DREAD, `OP_QREAD,
      `OP_QIO_READ, `OP_QIO_WREAD: c = FSS_CL_READ;
      `OP_PP, `OP_DPP, `OP_QPP: c = FSS_CL_PROG;
      `OP_SEQ_A, `OP_SEQ_B: c = FSS_CL_SEQ;
      `OP_BE4, `OP_BE32, `OP_BE64: c = FSS_CL_BERASE;
      `OP_CE_A, `OP_CE_B, `OP_WRSR_1, `OP_WRSR_2, `OP_WRSR_3,
      `OP_WRSR_IND, `OP_SR_LOCK, `OP_OTP_PROG: c = FSS_CL_FIXED;
      `OP_SUSPEND_FLAG_A, `OP_SUSPEND_FLAG_B: c = FSS_CL_SUSPEND_FLAG;
      `OP_RES_A, `OP_RES_B: c = FSS_CL_RES;
      default: c = FSS_CL_OTHER;
    endcase
    return c;
  endfunction

  function automatic logic needs_addr(input fss_cls_e c);
    logic r;
    r = (c == FSS_CL_READ) || (c == FSS_CL_PROG) ||
        (c == FSS_CL_SEQ) || (c == FSS_CL_BERASE);
    return r;
  endfunction

  // admission by current busy/suspend state
  function automatic logic permitted(input fss_cls_e  c,
                                     input fss_stat_s s,
                                     input fss_kind_e k,
                                     input fss_sq_e   sq,
                                     input logic      other_blk);
    logic ok;
    ok = 1'b0;
    if (s.busy_flag) begin
      case (c)
        FSS_CL_ANY: ok = 1'b1;
        // no second request while halting
        FSS_CL_SUSPEND_FLAG: ok = (k != FSS_K_FIXED) && (sq == FSS_SQ_IDLE);
        default: ok = 1'b0;
      endcase
    end else if (s.erase_suspended_flag || s.program_suspended_flag) begin
      case (c)
        FSS_CL_ANY, FSS_CL_SUSPOK, FSS_CL_READ: ok = 1'b1;
        FSS_CL_RES: ok = 1'b1;
        FSS_CL_PROG, FSS_CL_SEQ: begin
          ok = !s.program_suspended_flag && other_blk;
        end
        FSS_CL_BERASE, FSS_CL_FIXED: ok = 1'b0;
        default: ok = 1'b0;
      endcase
    end else begin
      ok = (c != FSS_CL_SUSPEND_FLAG) && (c != FSS_CL_RES);
    end
    return ok;
  endfunction

  function automatic logic in_region(input logic [23:0] a,
                                     input fss_stat_s   s,
                                     input logic [23:0] pg,
                                     input logic [23:0] blk);
    logic h;
    h = (s.program_suspended_flag &&
         a[23:`PAGE_LSB] == pg[23:`PAGE_LSB]) ||
        (s.erase_suspended_flag &&
         a[23:`BLK_LSB] == blk[23:`BLK_LSB]);
    return h;
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  localparam int unsigned             LAT_CYC  = `SUSE_CYC;
  localparam logic [`LAT_W-1:0]       LAT_LAST = LAT_CYC[`LAT_W-1:0] - 1'b1;

  fss_state_s q_r;
  fss_state_s q_nxt;
  logic       sck_rise;
  logic       cs_fall;
  logic       cs_rise;
  logic       frame_ok;
  logic       allowed;
  logic       write_latch_flag;
  fss_cls_e   cls;

  always_comb begin
    q_nxt = q_r;
    q_nxt.go = 1'b0;
    q_nxt.refused = 1'b0;
    // three-stage pin sync; a level counts once stages 2 and 3 agree
    q_nxt.sy1 = {si_i, sck_i, cs_n_i};
    q_nxt.sy2 = q_r.sy1;
    q_nxt.sy3 = q_r.sy2;
    q_nxt.filt = (q_r.sy2 & q_r.sy3) |
                 (q_r.filt & (q_r.sy2 ^ q_r.sy3));
    sck_rise = q_nxt.filt[`PIN_SCK] & ~q_r.filt[`PIN_SCK];
    cs_fall = ~q_nxt.filt[`PIN_CS] & q_r.filt[`PIN_CS];
    cs_rise = q_nxt.filt[`PIN_CS] & ~q_r.filt[`PIN_CS];
    cls = classify(q_r.op);
    write_latch_flag = write_latch_flag_i;
    frame_ok = (q_r.ph == 3'h0) && (q_r.cnt >= `OP_BITS) &&
               (!needs_addr(cls) || q_r.cnt >= `HDR_BITS);
    allowed = permitted(cls, q_r.stat, q_r.kind, q_r.sq,
                        q_r.addr[23:`BLK_LSB] !=
                        q_r.blk_addr[23:`BLK_LSB]);

    // ------------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------------
    if (cs_fall) begin
      q_nxt.cnt = 6'h00;
      q_nxt.ph = 3'h0;
      q_nxt.rd_undef = 1'b0;
    end else if (sck_rise && !q_nxt.filt[`PIN_CS]) begin
      q_nxt.sh = {q_r.sh[30:0], q_nxt.filt[`PIN_SI]};
      q_nxt.cnt = (q_r.cnt == `CNT_MAX) ? q_r.cnt : q_r.cnt + 6'h01;
      q_nxt.ph = q_r.ph + 3'h1;
      if (q_nxt.cnt == `OP_BITS) begin
        q_nxt.op = q_nxt.sh[7:0];
      end
      if (q_nxt.cnt == `HDR_BITS) begin
        q_nxt.addr = q_nxt.sh[23:0];
        // flagged only when the read itself is admitted
        q_nxt.rd_undef = (cls == FSS_CL_READ) && !q_r.stat.busy_flag &&
                         in_region(q_nxt.sh[23:0], q_r.stat,
                                   q_r.pg_addr, q_r.blk_addr);
      end
    end

    // ------------------------------------------------------------------
    // command admission at deselect
    // ------------------------------------------------------------------
    if (cs_rise) begin
      q_nxt.rd_undef = 1'b0;
      // a broken frame is dropped silently
      if (frame_ok) begin
        if (allowed) begin
          q_nxt.go = 1'b1;
          q_nxt.cmd.opcode = q_r.op;
          q_nxt.cmd.addr = q_r.addr;
          case (cls)
            FSS_CL_PROG: begin
              if (write_latch_flag) begin
                q_nxt.stat.busy_flag = 1'b1;
                q_nxt.kind = FSS_K_PROG;
                q_nxt.cur_addr = q_r.addr;
              end
            end
            FSS_CL_SEQ, FSS_CL_FIXED: begin
              if (write_latch_flag) begin
                q_nxt.stat.busy_flag = 1'b1;
                q_nxt.kind = FSS_K_FIXED;
              end
            end
            FSS_CL_BERASE: begin
              if (write_latch_flag) begin
                q_nxt.stat.busy_flag = 1'b1;
                q_nxt.kind = FSS_K_ERASE;
                q_nxt.cur_addr = q_r.addr;
              end
            end
            FSS_CL_SUSPEND_FLAG: begin
              // write latch deliberately not consulted
              q_nxt.sq = FSS_SQ_WAIT;
              q_nxt.lat = '0;
              q_nxt.halt = 1'b1;
            end
            FSS_CL_RES: begin
              // nested program resumes before the erase
              q_nxt.stat.busy_flag = 1'b1;
              q_nxt.stat.suspend_flag = q_r.stat.program_suspended_flag &
                                        q_r.stat.erase_suspended_flag;
              if (q_r.stat.program_suspended_flag) begin
                q_nxt.stat.program_suspended_flag = 1'b0;
                q_nxt.kind = FSS_K_PROG;
                q_nxt.cur_addr = q_r.pg_addr;
              end else begin
                q_nxt.stat.erase_suspended_flag = 1'b0;
                q_nxt.kind = FSS_K_ERASE;
                q_nxt.cur_addr = q_r.blk_addr;
              end
            end
            default: begin
            end
          endcase
        end else begin
          // nothing launched, so the core leaves the latch alone
          q_nxt.refused = 1'b1;
        end
      end
    end

    // ------------------------------------------------------------------
    // completion and suspend latency
    // ------------------------------------------------------------------
    case (q_r.sq)
      FSS_SQ_IDLE: begin
        if (op_done_i && q_r.stat.busy_flag) begin
          // a nested program ends here; the erase stays suspended
          q_nxt.stat.busy_flag = 1'b0;
          q_nxt.sq = FSS_SQ_IDLE;
          q_nxt.halt = 1'b0;
        end
      end
      FSS_SQ_WAIT: begin
        if (op_done_i) begin
          // finished before the halt took hold: nothing to suspend
          q_nxt.stat.busy_flag = 1'b0;
          q_nxt.sq = FSS_SQ_IDLE;
          q_nxt.halt = 1'b0;
        end else if (q_r.lat == LAT_LAST) begin
          q_nxt.sq = FSS_SQ_IDLE;
          q_nxt.halt = 1'b0;
          q_nxt.stat.busy_flag = 1'b0;
          q_nxt.stat.suspend_flag = 1'b1;
          if (q_r.kind == FSS_K_PROG) begin
            q_nxt.stat.program_suspended_flag = 1'b1;
            q_nxt.pg_addr = q_r.cur_addr;
          end else begin
            q_nxt.stat.erase_suspended_flag = 1'b1;
            q_nxt.blk_addr = q_r.cur_addr;
          end
        end else begin
          q_nxt.lat = q_r.lat + 1'b1;
        end
      end
      default: begin
        q_nxt.sq = FSS_SQ_IDLE;
        q_nxt.halt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
      q_r.sy1 <= `PIN_RST;
      q_r.sy2 <= `PIN_RST;
      q_r.sy3 <= `PIN_RST;
      q_r.filt <= `PIN_RST;
      q_r.sq <= FSS_SQ_IDLE;
      q_r.kind <= FSS_K_FIXED;
    end else begin
      q_r <= q_nxt;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign cmd_o = q_r.cmd;
  assign cmd_go_o = q_r.go;
  assign cmd_refused_o = q_r.refused;
  assign halt_req_o = q_r.halt;
  assign read_undef_o = q_r.rd_undef;
  assign status_o = q_r.stat;

endmodule

// >>> include/fss_regs.svh
// constants of the flash suspend command gate
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_READ        8'h03
`define OP_FREAD       8'h0B
`define OP_DREAD       8'h3B
`define OP_QREAD       8'h6B
`define OP_QIO_READ    8'hEB
`define OP_QIO_WREAD   8'hE7
`define OP_BE4         8'h20
`define OP_BE32        8'h52
`define OP_BE64        8'hD8
`define OP_CE_A        8'h60
`define OP_CE_B        8'hC7
`define OP_PP          8'h02
`define OP_DPP         8'hA2
`define OP_QPP         8'h32
`define OP_SEQ_A       8'hAD
`define OP_SEQ_B       8'hAF
`define OP_SUSPEND_FLAG_A      8'hB0
`define OP_SUSPEND_FLAG_B      8'h75
`define OP_RES_A       8'hD0
`define OP_RES_B       8'h7A
`define OP_WREN        8'h06
`define OP_WRDI        8'h04
`define OP_VWREN       8'h50
`define OP_BLK_LOCK    8'h36
`define OP_BLK_UNLOCK  8'h39
`define OP_GLB_LOCK    8'h7E
`define OP_GLB_UNLOCK  8'h98
`define OP_RD_LKS_A    8'h3C
`define OP_RD_LKS_B    8'h3D
`define OP_OTP_PROG    8'h9B
`define OP_OTP_READ    8'h4B
`define OP_RDSR_1      8'h05
`define OP_RDSR_2      8'h35
`define OP_RDSR_3      8'h15
`define OP_RDSR_IND    8'h65
`define OP_WRSR_1      8'h01
`define OP_WRSR_2      8'h31
`define OP_WRSR_3      8'h11
`define OP_WRSR_IND    8'h71
`define OP_SR_LOCK     8'h6F
`define OP_TERMINATE   8'hF0
`define OP_RST_EN      8'h66
`define OP_RST         8'h99
`define OP_ID_JEDEC    8'h9F
`define OP_ID_MFG      8'h90
`define OP_ID_QUAD     8'h94
`define OP_DPD         8'hB9
`define OP_UDPD        8'h79
`define OP_RDPD        8'hAB
`define OP_SFDP        8'h5A
`define OP_WRAP        8'h77

// ----------------------------------------------------------------------
// framing, regions, pins, timing
// ----------------------------------------------------------------------
`define OP_BITS        6'h08
`define HDR_BITS       6'h20
`define CNT_MAX        6'h3F
`define PAGE_LSB       8
`define BLK_LSB        16
`define PIN_CS         0
`define PIN_SCK        1
`define PIN_SI         2
`define PIN_RST        3'h1
`define CLK_MHZ        25
`define SUSE_NS        20000
`define SUSE_CYC       ((`SUSE_NS * `CLK_MHZ) / 1000)
`define LAT_W          10

`endif

// >>> include/fss_pkg.sv
// types of the flash suspend command gate
`include "fss_regs.svh"
package fss_pkg;

  typedef enum logic [3:0] {
    FSS_CL_ANY    = 4'h0,
    FSS_CL_SUSPOK = 4'h1,
    FSS_CL_READ   = 4'h2,
    FSS_CL_PROG   = 4'h3,
    FSS_CL_SEQ    = 4'h4,
    FSS_CL_BERASE = 4'h5,
    FSS_CL_FIXED  = 4'h6,
    FSS_CL_SUSPEND_FLAG   = 4'h7,
    FSS_CL_RES    = 4'h8,
    FSS_CL_OTHER  = 4'h9
  } fss_cls_e;

  typedef enum logic [1:0] {
    FSS_SQ_IDLE = 2'b01,
    FSS_SQ_WAIT = 2'b10
  } fss_sq_e;

  typedef enum logic [2:0] {
    FSS_K_PROG  = 3'b001,
    FSS_K_ERASE = 3'b010,
    FSS_K_FIXED = 3'b100
  } fss_kind_e;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
  } fss_cmd_s;

  typedef struct packed {
    logic busy_flag;
    logic suspend_flag;
    logic erase_suspended_flag;
    logic program_suspended_flag;
  } fss_stat_s;

  typedef struct packed {
    logic [2:0]         sy1;
    logic [2:0]         sy2;
    logic [2:0]         sy3;
    logic [2:0]         filt;
    logic [31:0]        sh;
    logic [5:0]         cnt;
    logic [2:0]         ph;
    logic [7:0]         op;
    logic [23:0]        addr;
    fss_sq_e            sq;
    logic [`LAT_W-1:0]  lat;
    fss_kind_e          kind;
    logic [23:0]        cur_addr;
    logic [23:0]        pg_addr;
    logic [23:0]        blk_addr;
    fss_stat_s          stat;
    logic               go;
    logic               refused;
    logic               halt;
    logic               rd_undef;
    fss_cmd_s           cmd;
  } fss_state_s;

endpackage

// >>> bench/fss_suspend_gate_props.sv
// port assertions of the suspend command gate
`timescale 1ns/1ps
module fss_suspend_gate_props
  import fss_pkg::*;
(
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // device core side
  input wire fss_pkg::fss_cmd_s  cmd_o,
  input wire logic               cmd_go_o,
  input wire logic               cmd_refused_o,
  input wire logic               halt_req_o,
  input wire logic               read_undef_o,
  input wire fss_pkg::fss_stat_s status_o
);
  logic [7:0] op;
  fss_stat_s  st;

  assign op = cmd_o.opcode;
  assign st = status_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // admission
  // ----------------------------------------------------------------
  a_go_refuse_excl: assert property (!(cmd_go_o && cmd_refused_o))
    else $error("go and refused together");
  a_busy_admit: assert property (cmd_go_o && $past(st.busy_flag) |->
    op inside {8'h05, 8'h35, 8'h15, 8'h65, 8'hF0, 8'h66, 8'h99, 8'h9F,
               8'h90, 8'h94, 8'hAB, 8'hB0, 8'h75})
    else $error("command admitted while busy");
  a_psusp_no_erase: assert property (cmd_go_o &&
    $past(st.program_suspended_flag) |->
    !(op inside {8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7}))
    else $error("erase admitted in program suspend");
  a_no_pdown: assert property (cmd_go_o &&
    ($past(st.busy_flag) || $past(st.suspend_flag)) |->
    !(op inside {8'hB9, 8'h79})) else $error("power-down admitted");
  a_otp_lock_rd: assert property (cmd_go_o &&
    op inside {8'h4B, 8'h3C, 8'h3D} |-> !$past(st.busy_flag))
    else $error("otp or lock read admitted while busy");
  // ----------------------------------------------------------------
  // suspend
  // ----------------------------------------------------------------
  a_halt_cause: assert property ($rose(halt_req_o) |->
    cmd_go_o && op inside {8'hB0, 8'h75}) else $error("halt without suspend");
  a_halt_bound: assert property (halt_req_o |-> ##[1:510] !halt_req_o)
    else $error("halt outlasts suspend latency");
  a_suspend_flag_flags: assert property ($fell(halt_req_o) &&
    st.suspend_flag |->
    !st.busy_flag && (st.erase_suspended_flag || st.program_suspended_flag))
    else $error("suspend flags wrong");
  a_suspend_flag_src: assert property ($rose(st.suspend_flag) |->
    $fell(halt_req_o))
    else $error("suspend flag set without halt");
  a_undef_suspend_flag: assert property (read_undef_o |-> st.suspend_flag)
    else $error("undefined read outside suspend");
endmodule

bind fss_suspend_gate fss_suspend_gate_props i_fss_suspend_gate_props (
  .clk_i         (clk_i),
  .rst_i         (rst_i),
  .cmd_o         (cmd_o),
  .cmd_go_o      (cmd_go_o),
  .cmd_refused_o (cmd_refused_o),
  .halt_req_o    (halt_req_o),
  .read_undef_o  (read_undef_o),
  .status_o      (status_o)
);

// >>> bench/fss_spi_host.sv
// spi host model driving command frames into the gate
`timescale 1ns/1ps
module fss_spi_host (
  // serial pins toward the device
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  // idle levels; the bench calls this once, so one process drives the pins
  task automatic idle;
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  endtask

  // mode 0, msb first; short or unaligned frames are sent on purpose
  task automatic xfer(input logic [31:0] bits, input int n);
    int i;
    cs_n_o = 1'b0;
    for (i = 0; i < n; i++) begin
      si_o = bits[31-i];
      #160 sck_o = 1'b1;
      #160 sck_o = 1'b0;
    end
    #160 cs_n_o = 1'b1;
    // released line: never leave the stale bit behind
    si_o = ~si_o;
    #320;
  endtask
endmodule

// >>> bench/test_fss_suspend_gate.sv
// self-checking bench of the suspend command gate
`timescale 1ns/1ps
module test_fss_suspend_gate;
  import fss_pkg::*;
  localparam logic [1:0] NONE = 2'h0, GO = 2'h1, REF = 2'h2;
  // opcode and expected answer while busy / in program suspend
  localparam logic [9:0] BT [20] = '{{8'h03, REF}, {8'h05, GO},
    {8'h65, GO}, {8'h9F, GO}, {8'h90, GO}, {8'h94, GO}, {8'hAB, GO},
    {8'hB9, REF}, {8'h79, REF}, {8'h4B, REF}, {8'h3C, REF}, {8'h3D, REF},
    {8'h06, REF}, {8'h77, REF}, {8'h7A, REF}, {8'h35, GO}, {8'h15, GO},
    {8'hF0, GO}, {8'h66, GO}, {8'h99, GO}};
  localparam logic [9:0] PT [23] = '{{8'hD8, REF}, {8'h20, REF},
    {8'h52, REF}, {8'h60, REF}, {8'hC7, REF}, {8'h02, REF}, {8'hAD, REF},
    {8'hB9, REF}, {8'h79, REF}, {8'hEB, GO}, {8'hE7, GO}, {8'h4B, GO},
    {8'h3C, GO}, {8'h5A, GO}, {8'h06, GO}, {8'hAB, GO}, {8'h0B, GO},
    {8'hA2, REF}, {8'h36, REF}, {8'h7E, REF}, {8'h04, GO}, {8'h50, GO},
    {8'h77, GO}};
  localparam logic [7:0] NS [7] = '{8'hC7, 8'h60, 8'h01, 8'h71, 8'h6F,
    8'h9B, 8'hAD};

  logic       clk_i, rst_i, write_latch_flag, op_done, cs_n, sck, si;
  logic       go, refused, halt, undef, undef_seen;
  logic [1:0] res;
  fss_cmd_s   cmd;
  fss_stat_s  stat;
  int         err_count, tests_run;
  int         n_go, n_ref, n_und;

  fss_suspend_gate i_fss_suspend_gate (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .write_latch_flag_i(write_latch_flag),
    .op_done_i(op_done), .cmd_o(cmd), .cmd_go_o(go),
    .cmd_refused_o(refused), .halt_req_o(halt), .read_undef_o(undef),
    .status_o(stat));
  fss_spi_host i_fss_spi_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // go and refused pulse for one cycle, undef holds until deselect; any may land while the host still idles
  // counters only; the sequence alone writes res and undef_seen
  always @(posedge clk_i) begin
    if (go === 1'b1) n_go <= n_go + 1;
    if (refused === 1'b1) n_ref <= n_ref + 1;
    if (undef === 1'b1) n_und <= n_und + 1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_cmd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a,
                      input int n, input logic [1:0] exp);
    int g0;
    int r0;
    int u0;
    g0 = n_go;
    r0 = n_ref;
    u0 = n_und;
    i_fss_spi_host.xfer({op, a}, n);
    cycles(8);
    res = (n_go != g0) ? GO : ((n_ref != r0) ? REF : NONE);
    undef_seen = (n_und != u0);
    check({2'b00, res}, {2'b00, exp});
  endtask
  task automatic pulse_done;
    cycles(1);
    op_done = 1'b1;
    cycles(1);
    op_done = 1'b0;
    cycles(2);
  endtask
  task automatic wait_halt;
    int i;
    i = 0;
    while (halt !== 1'b0 && i < 600) begin
      cycles(1);
      i++;
    end
    check({3'b000, halt}, 4'h0);
  endtask
  task automatic final_report;
    $display("TB: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    i_fss_spi_host.idle();
    write_latch_flag = 1'b1;
    op_done = 1'b0;
    res = NONE;
    undef_seen = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    cycles(4);
    send(8'h02, 24'h012300, 32, GO);
    check(stat, 4'h8);
    foreach (BT[i])
      send(BT[i][9:2], 24'h012300, 32, BT[i][1:0]);
    send(8'hB0, 24'h0, 12, NONE);
    send(8'h75, 24'h0, 4, NONE);
    check_cmd(cmd, {8'h99, 24'h012300});
    check(stat, 4'h8);
    write_latch_flag = 1'b0;
    send(8'hB0, 24'h0, 8, GO);
    check({3'b000, halt}, 4'h1);
    wait_halt();
    check(stat, 4'h5);
    $display("TB: busy admission and program suspend done");
    foreach (PT[i])
      send(PT[i][9:2], 24'h012345, 32, PT[i][1:0]);
    send(8'h03, 24'h012345, 32, GO);
    check({3'b000, undef_seen}, 4'h1);
    send(8'h03, 24'h020000, 32, GO);
    check_cmd(cmd, {8'h03, 24'h020000});
    check({3'b000, undef_seen}, 4'h0);
    send(8'h7A, 24'h0, 8, GO);
    check(stat, 4'h8);
    pulse_done();
    check(stat, 4'h0);
    $display("TB: program suspend admission done");
    write_latch_flag = 1'b1;
    send(8'hD8, 24'h050000, 32, GO);
    write_latch_flag = 1'b0;
    send(8'h75, 24'h0, 8, GO);
    wait_halt();
    check(stat, 4'h6);
    write_latch_flag = 1'b1;
    send(8'h02, 24'h05F000, 32, REF);
    send(8'hAD, 24'h05FF00, 32, REF);
    send(8'h03, 24'h051234, 32, GO);
    check({3'b000, undef_seen}, 4'h1);
    send(8'h02, 24'h060000, 32, GO);
    check_cmd(cmd, {8'h02, 24'h060000});
    check(stat, 4'hE);
    send(8'hB0, 24'h0, 8, GO);
    wait_halt();
    check(stat, 4'h7);
    send(8'h03, 24'h060010, 32, GO);
    check({3'b000, undef_seen}, 4'h1);
    send(8'h7A, 24'h0, 8, GO);
    check(stat, 4'hE);
    send(8'hD0, 24'h0, 8, REF);
    // host waits for the nested program to finish before resuming
    pulse_done();
    check(stat, 4'h6);
    send(8'hD0, 24'h0, 8, GO);
    check(stat, 4'h8);
    pulse_done();
    $display("TB: erase suspend and nested program done");
    foreach (NS[i]) begin
      send(NS[i], 24'h070000, 32, GO);
      send(8'hB0, 24'h0, 8, REF);
      cycles(520);
      check({halt, stat[3:1]}, 4'h4);
      pulse_done();
      check(stat, 4'h0);
    end
    $display("TB: non-suspendable operations done");
    final_report();
  end

  initial begin
    #2400000;
    err_count++;
    final_report();
  end
endmodule
